// File: inc/stspr_pkg.sv
// Package of constants and types for the status, poll and reset block
package stspr_pkg;
  localparam int SB_W = 8;
  localparam int GRP_W = 16;
  localparam int ERR_W = 8;
  localparam int ERR_DEPTH = 8;
  localparam int ERR_CNT_W = 4;
  localparam int VAL_W = 16;
  // Status summary byte field positions
  localparam int SB_ERRQ_BIT = 2;
  localparam int SB_GRPA_BIT = 3;
  localparam int SB_OBUF_BIT = 4;
  localparam int SB_EVSUM_BIT = 5;
  localparam int SB_RQS_BIT = 6;
  localparam int SB_OPER_BIT = 7;
  // Reset values
  localparam logic [SB_W-1:0] SB_RST = 8'h00;
  localparam logic [SB_W-1:0] MASK8_CLR = 8'h00;
  localparam logic [GRP_W-1:0] GRP_ENA_PRESET = 16'h0000;
  localparam logic [GRP_W-1:0] RISE_PRESET = 16'hFFFF;
  localparam logic [GRP_W-1:0] FALL_PRESET = 16'h0000;
  localparam logic [ERR_W-1:0] NO_ERROR_CODE = 8'h00;
  // Register selectors for queries and writes
  typedef enum logic [3:0] {
    STSPR_SEL_SUMMARY, STSPR_SEL_EVENT, STSPR_SEL_REQ_MASK, STSPR_SEL_EVT_MASK, STSPR_SEL_POLL_MASK,
    STSPR_SEL_A_EVT, STSPR_SEL_A_ENA, STSPR_SEL_A_PTR, STSPR_SEL_A_NTR, STSPR_SEL_A_COND,
    STSPR_SEL_O_EVT, STSPR_SEL_O_ENA, STSPR_SEL_O_PTR, STSPR_SEL_O_NTR, STSPR_SEL_O_COND,
    STSPR_SEL_IST
  } stspr_sel_t;
endpackage

// File: rtl/stspr_core.sv
// Status reporting core: poll bit, weighted queries, error queue, reset sources
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - The poll bit is the OR of poll mask AND status byte, bit 6 included, optionally inverted, on the allotted line.
// - One poll command makes up to eight devices answer at once, each driving only its own line.
// - The same combined poll bit answers an individual-status query without a poll.
// - Status byte and event status register are 8 bits, the two group registers 16 bits.
// - A query returns one number equal to the sum of the weights 2**n of the set bits.
// - Status byte bit 3 is the group A summary and bit 5 the event status summary.
// - An error pushes one queue entry unless eight are stored and no pop comes in that cycle, which sets overflow; err_count reports the entries stored.
// - Each next-error query pops one entry, and an empty queue answers code 0.
// - Power-on and device clear flush command processing and buffers, power-on also the queue.
// - Power-on with flag 1 zeroes status, events, masks; clear-status zeroes status, events, queue.
// - Preset and power-on with flag 1 zero group enables; preset leaves the 8-bit masks, which power-on with flag 1 zeroes.
// - Preset and power-on with flag 1 fill rising filters with ones and zero falling filters.
// - The output buffer clears on the first command of a line.
// - A service request rises when status bits 2,3,4,5 or 7 are set and enabled.
module stspr_core
  import stspr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic power_on,
  input wire logic power_on_clear_flag,
  input wire logic dev_clear,
  input wire logic status_preset,
  input wire logic clear_status,
  input wire logic first_cmd_of_line,
  input wire logic [stspr_pkg::SB_W-1:0] event_set,
  input wire logic [stspr_pkg::GRP_W-1:0] group_a_cond_in,
  input wire logic [stspr_pkg::GRP_W-1:0] oper_cond_in,
  input wire logic obuf_not_empty,
  input wire logic wr_en,
  input wire stspr_pkg::stspr_sel_t wr_sel,
  input wire logic [stspr_pkg::VAL_W-1:0] wr_data,
  input wire logic poll_sense,
  input wire logic [2:0] poll_line,
  input wire logic poll_active,
  input wire logic rd_en,
  input wire stspr_pkg::stspr_sel_t rd_sel,
  output logic [stspr_pkg::VAL_W-1:0] rd_value,
  output logic rd_valid,
  input wire logic err_push,
  input wire logic [stspr_pkg::ERR_W-1:0] err_code,
  input wire logic err_pop,
  output logic [stspr_pkg::ERR_W-1:0] err_pop_code,
  output logic [stspr_pkg::ERR_CNT_W-1:0] err_count,
  output logic err_overflow,
  output logic [7:0] poll_data_out,
  output logic [7:0] poll_data_oe_n,
  output logic ist_bit,
  output logic srq,
  output logic flush_cmd_proc,
  output logic flush_in_buf,
  output logic flush_out_buf
);
  import stspr_pkg::*;

  logic [SB_W-1:0] event_status_reg;
  logic [SB_W-1:0] req_mask_reg;
  logic [SB_W-1:0] evt_mask_reg;
  logic [SB_W-1:0] poll_mask_reg;
  logic [GRP_W-1:0] a_evt_reg, a_ena_reg, a_ptr_reg, a_ntr_reg, a_cond_reg, a_sync_reg;
  logic [GRP_W-1:0] o_evt_reg, o_ena_reg, o_ptr_reg, o_ntr_reg, o_cond_reg, o_sync_reg;
  logic [SB_W-1:0] status_low;
  logic [SB_W-1:0] status_byte;
  logic full_clear;
  logic preset_all;
  logic status_clear;
  logic ist_next;
  logic [GRP_W-1:0] a_trans;
  logic [GRP_W-1:0] o_trans;
  logic errq_flush;

  //////////////////////////////////////////////////////////////////////////////
  // Clearing event decode
  assign full_clear = power_on && power_on_clear_flag;
  assign preset_all = full_clear || status_preset;
  assign status_clear = full_clear || clear_status;
  assign errq_flush = power_on || clear_status;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flush_cmd_proc <= 1'b0;
      flush_in_buf <= 1'b0;
      flush_out_buf <= 1'b0;
    end else begin
      flush_cmd_proc <= power_on || dev_clear;
      flush_in_buf <= power_on || dev_clear;
      flush_out_buf <= power_on || dev_clear || first_cmd_of_line;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Condition sampling and transition filters; set beats clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      a_sync_reg <= '0;
      a_cond_reg <= '0;
      o_sync_reg <= '0;
      o_cond_reg <= '0;
    end else begin
      a_sync_reg <= group_a_cond_in;
      a_cond_reg <= a_sync_reg;
      o_sync_reg <= oper_cond_in;
      o_cond_reg <= o_sync_reg;
    end
  end

  // Group condition registers are updated each cycle; edges come from last cycle
  logic [GRP_W-1:0] a_prev_reg, o_prev_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      a_prev_reg <= '0;
      o_prev_reg <= '0;
    end else begin
      a_prev_reg <= a_cond_reg;
      o_prev_reg <= o_cond_reg;
    end
  end

  assign a_trans = (a_cond_reg & ~a_prev_reg & a_ptr_reg) | (~a_cond_reg & a_prev_reg & a_ntr_reg);
  assign o_trans = (o_cond_reg & ~o_prev_reg & o_ptr_reg) | (~o_cond_reg & o_prev_reg & o_ntr_reg);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      a_evt_reg <= '0;
      o_evt_reg <= '0;
      event_status_reg <= SB_RST;
    end else begin
      a_evt_reg <= (status_clear ? '0 : a_evt_reg) | a_trans;
      o_evt_reg <= (status_clear ? '0 : o_evt_reg) | o_trans;
      event_status_reg <= (status_clear ? SB_RST : event_status_reg) | event_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable masks and filters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      req_mask_reg <= MASK8_CLR;
      evt_mask_reg <= MASK8_CLR;
      poll_mask_reg <= MASK8_CLR;
    end else if (full_clear) begin
      req_mask_reg <= MASK8_CLR;
      evt_mask_reg <= MASK8_CLR;
      poll_mask_reg <= MASK8_CLR;
    end else if (wr_en) begin
      case (wr_sel)
        STSPR_SEL_REQ_MASK: req_mask_reg <= wr_data[SB_W-1:0];
        STSPR_SEL_EVT_MASK: evt_mask_reg <= wr_data[SB_W-1:0];
        STSPR_SEL_POLL_MASK: poll_mask_reg <= wr_data[SB_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || preset_all) begin
      a_ena_reg <= GRP_ENA_PRESET;
      o_ena_reg <= GRP_ENA_PRESET;
      a_ptr_reg <= RISE_PRESET;
      o_ptr_reg <= RISE_PRESET;
      a_ntr_reg <= FALL_PRESET;
      o_ntr_reg <= FALL_PRESET;
    end else if (wr_en) begin
      case (wr_sel)
        STSPR_SEL_A_ENA: a_ena_reg <= wr_data;
        STSPR_SEL_A_PTR: a_ptr_reg <= wr_data;
        STSPR_SEL_A_NTR: a_ntr_reg <= wr_data;
        STSPR_SEL_O_ENA: o_ena_reg <= wr_data;
        STSPR_SEL_O_PTR: o_ptr_reg <= wr_data;
        STSPR_SEL_O_NTR: o_ntr_reg <= wr_data;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status summary byte
  always_comb begin
    status_low = SB_RST;
    status_low[SB_ERRQ_BIT] = (err_count != '0);
    status_low[SB_GRPA_BIT] = |(a_evt_reg & a_ena_reg);
    status_low[SB_OBUF_BIT] = obuf_not_empty;
    status_low[SB_EVSUM_BIT] = |(event_status_reg & evt_mask_reg);
    status_low[SB_OPER_BIT] = |(o_evt_reg & o_ena_reg);
  end

  // Summary bit formed apart so that it never reads its own output
  always_comb begin
    status_byte = status_low;
    status_byte[SB_RQS_BIT] = |(status_low & req_mask_reg);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      srq <= 1'b0;
    end else begin
      srq <= status_byte[SB_RQS_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parallel poll and individual status
  assign ist_next = (|(poll_mask_reg & status_byte)) ^ ~poll_sense;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ist_bit <= 1'b0;
    end else begin
      ist_bit <= ist_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_line
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          poll_data_out[gi] <= 1'b0;
          poll_data_oe_n[gi] <= 1'b1;
        end else begin
          poll_data_out[gi] <= ist_next;
          poll_data_oe_n[gi] <= !(poll_active && (poll_line == 3'(gi)));
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Weighted queries: the binary value is the sum of 2**n over set bits
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_value <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        case (rd_sel)
          STSPR_SEL_SUMMARY: rd_value <= {8'h00, status_byte};
          STSPR_SEL_EVENT: rd_value <= {8'h00, event_status_reg};
          STSPR_SEL_REQ_MASK: rd_value <= {8'h00, req_mask_reg};
          STSPR_SEL_EVT_MASK: rd_value <= {8'h00, evt_mask_reg};
          STSPR_SEL_POLL_MASK: rd_value <= {8'h00, poll_mask_reg};
          STSPR_SEL_A_EVT: rd_value <= a_evt_reg;
          STSPR_SEL_A_ENA: rd_value <= a_ena_reg;
          STSPR_SEL_A_PTR: rd_value <= a_ptr_reg;
          STSPR_SEL_A_NTR: rd_value <= a_ntr_reg;
          STSPR_SEL_A_COND: rd_value <= a_cond_reg;
          STSPR_SEL_O_EVT: rd_value <= o_evt_reg;
          STSPR_SEL_O_ENA: rd_value <= o_ena_reg;
          STSPR_SEL_O_PTR: rd_value <= o_ptr_reg;
          STSPR_SEL_O_NTR: rd_value <= o_ntr_reg;
          STSPR_SEL_O_COND: rd_value <= o_cond_reg;
          STSPR_SEL_IST: rd_value <= {15'h0000, ist_next};
          default: rd_value <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error queue
  stspr_errq u_errq (
    .mclk(mclk),
    .rst_n(rst_n),
    .flush(errq_flush),
    .push(err_push),
    .push_code(err_code),
    .pop(err_pop),
    .pop_code(err_pop_code),
    .count(err_count),
    .overflow(err_overflow)
  );
endmodule

// File: rtl/stspr_errq.sv
// Error queue: push on error, pop one entry per next-error query
`timescale 1ns/1ps
module stspr_errq
  import stspr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [stspr_pkg::ERR_W-1:0] push_code,
  input wire logic pop,
  output logic [stspr_pkg::ERR_W-1:0] pop_code,
  output logic [stspr_pkg::ERR_CNT_W-1:0] count,
  output logic overflow
);
  logic [ERR_W-1:0] mem [ERR_DEPTH];
  logic [2:0] rd_reg;
  logic [2:0] wr_reg;
  logic do_push;
  logic do_pop;

  assign do_pop = pop && (count != '0);
  assign do_push = push && ((count != ERR_CNT_W'(ERR_DEPTH)) || do_pop);

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_reg] <= push_code;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || flush) begin
      rd_reg <= '0;
      wr_reg <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 3'h1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 3'h1;
      end
      count <= count + ERR_CNT_W'(do_push) - ERR_CNT_W'(do_pop);
    end
  end

  // Empty queue answers with the no-error code
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pop_code <= NO_ERROR_CODE;
    end else if (pop) begin
      pop_code <= do_pop ? mem[rd_reg] : NO_ERROR_CODE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || flush) begin
      overflow <= 1'b0;
    end else if (push && !do_push) begin
      overflow <= 1'b1;
    end
  end
endmodule

// File: testbench/stspr_core_monitor.sv
// Checker of the status, poll and reset core seen from its ports
`timescale 1ns/1ps
module stspr_core_monitor
  import stspr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire stspr_pkg::stspr_sel_t rd_sel,
  input wire logic rd_valid,
  input wire logic [15:0] rd_value,
  input wire logic wr_en,
  input wire logic dev_clear,
  input wire logic first_cmd_of_line,
  input wire logic flush_cmd_proc,
  input wire logic flush_in_buf,
  input wire logic flush_out_buf,
  input wire logic err_push,
  input wire logic err_pop,
  input wire logic [3:0] err_count,
  input wire logic [7:0] err_pop_code,
  input wire logic clear_status,
  input wire logic power_on,
  input wire logic status_preset,
  input wire logic poll_active,
  input wire logic [2:0] poll_line,
  input wire logic [7:0] poll_data_out,
  input wire logic [7:0] poll_data_oe_n,
  input wire logic ist_bit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_preset_then_ptr_read;
    status_preset ##1 !wr_en ##1 (rd_en && rd_sel == STSPR_SEL_A_PTR && !wr_en);
  endsequence
  property p_rd_valid; rd_en |=> rd_valid; endproperty
  property p_dev_flush;
    dev_clear |=> flush_cmd_proc && flush_in_buf && flush_out_buf;
  endproperty
  property p_line_flush; first_cmd_of_line |=> flush_out_buf; endproperty
  property p_pop_empty;
    err_pop && !err_push && err_count == 4'h0 |=> err_pop_code == 8'h00 && err_count == 4'h0;
  endproperty
  property p_queue_clear;
    (clear_status || power_on) && !err_push |=> err_count == 4'h0;
  endproperty
  property p_one_line; poll_active |=> poll_data_oe_n == ~(8'h01 << $past(poll_line)); endproperty
  property p_idle_lines; !poll_active |=> poll_data_oe_n == 8'hFF; endproperty
  property p_lines_match; poll_data_out == {8{ist_bit}}; endproperty
  property p_preset_ptr; s_preset_then_ptr_read |=> rd_value == 16'hFFFF; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("query answer missing");
  a_dev_flush: assert property (p_dev_flush) else $error("device clear flush missing");
  a_line_flush: assert property (p_line_flush) else $error("output flush missing");
  a_pop_empty: assert property (p_pop_empty) else $error("empty pop not zero");
  a_queue_clear: assert property (p_queue_clear) else $error("queue not cleared");
  a_one_line: assert property (p_one_line) else $error("wrong poll line driven");
  a_idle_lines: assert property (p_idle_lines) else $error("poll line driven idle");
  a_lines_match: assert property (p_lines_match) else $error("poll line differs");
  a_preset_ptr: assert property (p_preset_ptr) else $error("rising filter not preset");
endmodule
bind stspr_core stspr_core_monitor u_mon (.mclk, .rst_n, .rd_en, .rd_sel, .rd_valid, .rd_value,
  .wr_en, .dev_clear, .first_cmd_of_line, .flush_cmd_proc, .flush_in_buf, .flush_out_buf,
  .err_push, .err_pop, .err_count, .err_pop_code, .clear_status, .power_on, .status_preset,
  .poll_active, .poll_line, .poll_data_out, .poll_data_oe_n, .ist_bit);

// File: testbench/stspr_ctrl_model.sv
// Controller side of the poll lines: pulled-up bus and sampling of one line
`timescale 1ns/1ps
module stspr_ctrl_model (
  input wire logic [7:0] poll_data_out,
  input wire logic [7:0] poll_data_oe_n,
  input wire logic [2:0] poll_line,
  output logic [7:0] poll_bus,
  output logic line_bit,
  output logic [3:0] drivers
);
  // Undriven lines float to the pull-up level
  always_comb begin
    drivers = 4'h0;
    for (int i = 0; i < 8; i++) begin
      poll_bus[i] = poll_data_oe_n[i] ? 1'b1 : poll_data_out[i];
      drivers = drivers + {3'h0, ~poll_data_oe_n[i]};
    end
    line_bit = poll_bus[poll_line];
  end
endmodule

// File: testbench/tb_stspr_core.sv
// Self-checking testbench of the status, poll and reset core
`timescale 1ns/1ps
module tb_stspr_core;
  import stspr_pkg::*;
  logic mclk = 0, rst_n = 0, power_on = 0, pflag = 0, dev_clear = 0, status_preset = 0;
  logic clear_status = 0, fcl = 0, wr_en = 0, poll_sense = 1, poll_active = 0, rd_en = 0;
  logic err_push = 0, err_pop = 0, rd_valid, err_overflow, ist_bit, srq, line_bit;
  logic obuf = 0, fcp, fib, fob;
  logic [7:0] event_set = 0, err_code = 0, err_pop_code, poll_data_out, poll_data_oe_n;
  logic [15:0] ga_cond = 0, op_cond = 0, wr_data = 0, rd_value;
  logic [3:0] err_count, drivers;
  logic [2:0] poll_line = 0;
  stspr_sel_t wr_sel = STSPR_SEL_SUMMARY, rd_sel = STSPR_SEL_SUMMARY;
  integer seed = 42213, miscompares = 0, check_count = 0, evt_m;
  logic [7:0] q[$];
  stspr_core u_dut (.mclk, .rst_n, .power_on, .power_on_clear_flag(pflag), .dev_clear,
    .status_preset, .clear_status, .first_cmd_of_line(fcl), .event_set, .group_a_cond_in(ga_cond),
    .oper_cond_in(op_cond), .obuf_not_empty(obuf), .wr_en, .wr_sel, .wr_data, .poll_sense,
    .poll_line, .poll_active, .rd_en, .rd_sel, .rd_value, .rd_valid, .err_push, .err_code,
    .err_pop, .err_pop_code, .err_count, .err_overflow, .poll_data_out, .poll_data_oe_n,
    .ist_bit, .srq, .flush_cmd_proc(fcp), .flush_in_buf(fib), .flush_out_buf(fob));
  stspr_ctrl_model u_ctrl (.poll_data_out, .poll_data_oe_n, .poll_line, .poll_bus(),
    .line_bit, .drivers);
  always #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input stspr_sel_t s, input logic [15:0] d);
    wr_en = 1; wr_sel = s; wr_data = d;
    step; wr_en = 0; step;
  endtask
  task automatic rd(input stspr_sel_t s, input logic [15:0] exp);
    rd_en = 1; rd_sel = s;
    step; rd_en = 0;
    chk({15'h0, rd_valid}, 16'h1);
    chk(rd_value, exp);
    step;
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ga_cond = 16'($random(seed));
    op_cond = 16'($random(seed));
    step(4); rst_n = 1; step;
    rd(STSPR_SEL_A_PTR, 16'hFFFF);
    rd(STSPR_SEL_A_NTR, 16'h0000);
    rd(STSPR_SEL_A_ENA, 16'h0000);
    rd(STSPR_SEL_REQ_MASK, 16'h0000);
    // Fill past depth, then drain past empty
    for (int i = 0; i < 9; i++) begin
      err_push = 1; err_code = 8'($random(seed));
      if (q.size() < 8) q.push_back(err_code);
      step; err_push = 0; step;
    end
    chk({12'h0, err_count}, 16'(q.size()));
    chk({15'h0, err_overflow}, 16'h1);
    for (int i = 0; i < 9; i++) begin
      err_pop = 1; step; err_pop = 0;
      chk({8'h0, err_pop_code}, {8'h0, q.size() > 0 ? q.pop_front() : 8'h00});
      chk({12'h0, err_count}, 16'(q.size()));
      step;
    end
    evt_m = ($random(seed) & 8'hFF) | 1;
    event_set = evt_m[7:0]; step; event_set = 0; step;
    wr(STSPR_SEL_EVT_MASK, 16'h00FF);
    wr(STSPR_SEL_REQ_MASK, 16'h0020);
    wr(STSPR_SEL_POLL_MASK, 16'h0020);
    rd(STSPR_SEL_EVENT, evt_m[15:0]);
    rd(STSPR_SEL_SUMMARY, 16'h0060);
    chk({15'h0, srq}, 16'h1);
    // Controller reads the error queue after the service request
    err_pop = 1; step; err_pop = 0;
    chk({8'h0, err_pop_code}, 16'h0000);
    step;
    rd(STSPR_SEL_IST, 16'h0001);
    poll_line = 3'($random(seed)); poll_active = 1; step(2);
    chk({15'h0, line_bit}, 16'h1);
    chk({15'h0, ist_bit}, 16'h1);
    chk({12'h0, drivers}, 16'h1);
    poll_sense = 0; step(2);
    chk({15'h0, line_bit}, 16'h0);
    chk({15'h0, ist_bit}, 16'h0);
    poll_active = 0; poll_sense = 1;
    err_push = 1; step; err_push = 0; clear_status = 1; step; clear_status = 0; step;
    chk({12'h0, err_count}, 16'h0);
    rd(STSPR_SEL_EVENT, 16'h0000);
    rd(STSPR_SEL_SUMMARY, 16'h0000);
    wr(STSPR_SEL_A_PTR, 16'h0000);
    wr(STSPR_SEL_A_ENA, 16'h1234);
    rd(STSPR_SEL_A_ENA, 16'h1234);
    status_preset = 1; step; status_preset = 0; step;
    rd(STSPR_SEL_A_PTR, 16'hFFFF);
    rd(STSPR_SEL_A_ENA, 16'h0000);
    err_push = 1; step; err_push = 0; dev_clear = 1; step; dev_clear = 0; fcl = 1;
    chk({13'h0, fcp, fib, fob}, 16'h0007);
    step; fcl = 0;
    chk({13'h0, fcp, fib, fob}, 16'h0001);
    chk({12'h0, err_count}, 16'h1);
    power_on = 1; step; power_on = 0; step;
    chk({12'h0, err_count}, 16'h0);
    rd(STSPR_SEL_REQ_MASK, 16'h0020);
    pflag = 1; power_on = 1; step; power_on = 0; step;
    rd(STSPR_SEL_REQ_MASK, 16'h0000);
    rd(STSPR_SEL_POLL_MASK, 16'h0000);
    // Group rising edge and output buffer level both reach the summary byte
    ga_cond = 16'h0000; step(4);
    wr(STSPR_SEL_A_ENA, 16'h0001);
    obuf = 1; ga_cond = 16'h0001;
    wr(STSPR_SEL_REQ_MASK, 16'h0010); step(2);
    chk({15'h0, srq}, 16'h1);
    rd(STSPR_SEL_A_EVT, 16'h0001);
    rd(STSPR_SEL_SUMMARY, 16'h0058);
    report_and_stop;
  end
endmodule
